/* pkg/tsg_pkg.sv */
/*
  package for the tile security and debug-access guard: register offsets,
  security word field positions, test port codes and timing counts.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tsg_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] DEBUG_PERMISSION_CONTROL_OFS    = 8'h04;
  localparam logic [7:0] SECURITY_CONFIGURATION_OFS      = 8'h05;
  localparam logic [7:0] SECURITY_CONFIGURATION_COPY_OFS = 8'h07;
  localparam logic [7:0] SECURE_TEST_CTRL_OFS            = 8'h08;

  // ==========================================================
  // security word fields
  localparam int SEC_NO_TEST_PORT_BIT = 0;
  localparam int SEC_NO_LINK_BIT      = 1;
  localparam int SEC_SECURE_BOOT_BIT  = 5;
  localparam int SEC_REDUNDANT_BIT    = 7;
  localparam int SEC_SECTOR_LOCK_LSB  = 8;
  localparam int SEC_SECTORS          = 4;
  localparam int SEC_MASTER_LOCK_BIT  = 12;
  localparam int SEC_NO_TEST_OTP_BIT  = 13;
  localparam int SEC_GP_LSB           = 15;
  localparam int SEC_GP_MSB           = 21;
  localparam int SEC_USERID_LSB       = 22;
  localparam int SEC_USERID_MSB       = 31;
  localparam int PERM_RO_BIT          = 31;

  // ==========================================================
  // reset values and boot addresses
  localparam logic [31:0] SEC_RESET_VAL  = 32'h0000_0000;
  localparam logic [31:0] PERM_RESET_VAL = 32'h0000_0000;
  localparam logic [31:0] BOOT_ROM_ADDR  = 32'h0000_0000;
  localparam logic [31:0] OTP_BOOT_ADDR  = 32'h0000_0000;

  // ==========================================================
  // test port
  localparam int          TAP_IR_W      = 4;
  localparam int          TAP_DR_W      = 32;
  localparam logic [3:0]  IR_EXTEST     = 4'h0;
  localparam logic [3:0]  IR_IDCODE     = 4'h1;
  localparam logic [3:0]  IR_SAMPLE     = 4'h2;
  localparam logic [3:0]  IR_CHIP_TAP   = 4'h8;
  localparam logic [3:0]  IR_OTP_ACCESS = 4'h9;
  localparam logic [3:0]  IR_USERCODE   = 4'hE;
  localparam logic [3:0]  IR_BYPASS     = 4'hF;
  // arbitrary neutral values
  localparam logic [3:0]  ID_VERSION    = 4'h0;
  localparam logic [15:0] ID_PART       = 16'h0001;
  localparam logic [10:0] ID_MAKER      = 11'h0_2A;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int TRST_MIN_NS     = 100;
  localparam int TRST_MIN_CYCLES = (TRST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // ==========================================================
  // tap states
  typedef enum logic [15:0] {
    TS_RESET  = 16'h0001, TS_IDLE   = 16'h0002, TS_SELDR  = 16'h0004,
    TS_CAPDR  = 16'h0008, TS_SHDR   = 16'h0010, TS_EX1DR  = 16'h0020,
    TS_PAUSDR = 16'h0040, TS_EX2DR  = 16'h0080, TS_UPDDR  = 16'h0100,
    TS_SELIR  = 16'h0200, TS_CAPIR  = 16'h0400, TS_SHIR   = 16'h0800,
    TS_EX1IR  = 16'h1000, TS_PAUSIR = 16'h2000, TS_EX2IR  = 16'h4000,
    TS_UPDIR  = 16'h8000
  } tsg_tap_state_t;
endpackage

/* logic/tsg_sync.sv */
/*
  two flip-flop synchroniser for a level, one per bit.
  assumes the input is asynchronous to clk.
*/
module tsg_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // level
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      dout   <= '0;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule

/* logic/tsg_tap.sv */
/*
  boundary-scan test access port on the test clock: state machine,
  4-bit instruction and 32-bit data register, id and user codes.
  assumes trstN is the asynchronous-asserting test reset and that
  gating levels arrive already synchronised to tck.
*/
module tsg_tap (
  // test pins
  input  wire logic        tck,
  input  wire logic        trstN,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdoEn,
  // gating levels in tck domain
  input  wire logic        blockTile,
  input  wire logic        blockOtp,
  input  wire logic [9:0]  userIdExt,
  // updated data word toward the tile
  output logic [31:0]      updWord,
  output logic [3:0]       updIr,
  output logic             updToggle
);
  tsg_pkg::tsg_tap_state_t state, stateNxt;
  logic [3:0]  ir_r, irShift_r;
  logic [31:0] dr_r;
  logic        bypass_r;
  logic        drLong;

  // ==========================================================
  // state machine
  always_comb begin
    stateNxt = tsg_pkg::TS_RESET;
    case (state)
      tsg_pkg::TS_RESET:  stateNxt = tms ? tsg_pkg::TS_RESET : tsg_pkg::TS_IDLE;
      tsg_pkg::TS_IDLE:   stateNxt = tms ? tsg_pkg::TS_SELDR : tsg_pkg::TS_IDLE;
      tsg_pkg::TS_SELDR:  stateNxt = tms ? tsg_pkg::TS_SELIR : tsg_pkg::TS_CAPDR;
      tsg_pkg::TS_CAPDR:  stateNxt = tms ? tsg_pkg::TS_EX1DR : tsg_pkg::TS_SHDR;
      tsg_pkg::TS_SHDR:   stateNxt = tms ? tsg_pkg::TS_EX1DR : tsg_pkg::TS_SHDR;
      tsg_pkg::TS_EX1DR:  stateNxt = tms ? tsg_pkg::TS_UPDDR : tsg_pkg::TS_PAUSDR;
      tsg_pkg::TS_PAUSDR: stateNxt = tms ? tsg_pkg::TS_EX2DR : tsg_pkg::TS_PAUSDR;
      tsg_pkg::TS_EX2DR:  stateNxt = tms ? tsg_pkg::TS_UPDDR : tsg_pkg::TS_SHDR;
      tsg_pkg::TS_UPDDR:  stateNxt = tms ? tsg_pkg::TS_SELDR : tsg_pkg::TS_IDLE;
      tsg_pkg::TS_SELIR:  stateNxt = tms ? tsg_pkg::TS_RESET : tsg_pkg::TS_CAPIR;
      tsg_pkg::TS_CAPIR:  stateNxt = tms ? tsg_pkg::TS_EX1IR : tsg_pkg::TS_SHIR;
      tsg_pkg::TS_SHIR:   stateNxt = tms ? tsg_pkg::TS_EX1IR : tsg_pkg::TS_SHIR;
      tsg_pkg::TS_EX1IR:  stateNxt = tms ? tsg_pkg::TS_UPDIR : tsg_pkg::TS_PAUSIR;
      tsg_pkg::TS_PAUSIR: stateNxt = tms ? tsg_pkg::TS_EX2IR : tsg_pkg::TS_PAUSIR;
      tsg_pkg::TS_EX2IR:  stateNxt = tms ? tsg_pkg::TS_UPDIR : tsg_pkg::TS_SHIR;
      tsg_pkg::TS_UPDIR:  stateNxt = tms ? tsg_pkg::TS_SELDR : tsg_pkg::TS_IDLE;
      default:            stateNxt = tsg_pkg::TS_RESET;
    endcase
  end

  // held in reset while trstN low
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) state <= tsg_pkg::TS_RESET;
    else        state <= stateNxt;
  end

  // ==========================================================
  // instruction register
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      ir_r      <= tsg_pkg::IR_IDCODE;
      irShift_r <= 4'h0;
    end else begin
      case (state)
        tsg_pkg::TS_RESET: ir_r      <= tsg_pkg::IR_IDCODE;
        tsg_pkg::TS_CAPIR: irShift_r <= 4'h1;
        tsg_pkg::TS_SHIR:  irShift_r <= {tdi, irShift_r[3:1]};
        tsg_pkg::TS_UPDIR: ir_r      <= irShift_r;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // data registers
  assign drLong = (ir_r != tsg_pkg::IR_BYPASS);

  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      dr_r      <= 32'h0000_0000;
      bypass_r  <= 1'b0;
      updWord   <= 32'h0000_0000;
      updIr     <= 4'h0;
      updToggle <= 1'b0;
    end else begin
      case (state)
        tsg_pkg::TS_CAPDR: begin
          bypass_r <= 1'b0;
          case (ir_r)
            tsg_pkg::IR_IDCODE:   dr_r <= {tsg_pkg::ID_VERSION, tsg_pkg::ID_PART,
                                           tsg_pkg::ID_MAKER, 1'b1}; // R14
            tsg_pkg::IR_USERCODE: dr_r <= {userIdExt, 22'h00_0000}; // R9
            default:              dr_r <= 32'h0000_0000;
          endcase
        end
        tsg_pkg::TS_SHDR: begin
          dr_r     <= {tdi, dr_r[31:1]};
          bypass_r <= tdi;
        end
        tsg_pkg::TS_UPDDR: begin
          // tile and otp traffic dropped when locked out
          if ((ir_r == tsg_pkg::IR_CHIP_TAP && !blockTile) ||
              (ir_r == tsg_pkg::IR_OTP_ACCESS && !blockOtp)) begin // R1 R7 R11
            updWord   <= dr_r;
            updIr     <= ir_r;
            updToggle <= ~updToggle;
          end
        end
        default: ;
      endcase
    end
  end

  // ==========================================================
  // tdo on falling edge
  always_ff @(negedge tck or negedge trstN) begin
    if (!trstN) begin
      tdo   <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      tdoEn <= (state == tsg_pkg::TS_SHDR) || (state == tsg_pkg::TS_SHIR);
      if (state == tsg_pkg::TS_SHIR) tdo <= irShift_r[0];
      else                           tdo <= drLong ? dr_r[0] : bypass_r;
    end
  end
endmodule

/* logic/tsg_guard.sv */
/*
  tile security and debug-access guard: security word from otp, its
  lock decoding, status register and configuration register access,
  and the test port joined over a clock crossing.
  assumes the otp loader presents the security word with a one-cycle
  valid strobe after reset, and that request strobes are sys_clk pulses.
*/
// Behaviour
// [R1] security bit 0 blocks all test-port access to tile state and memory.
// [R2] security bit 1 refuses switch access from other tiles to processor state.
// [R3] security bit 5 boots from otp address 0, skipping the boot rom.
// [R4] security bit 7 enables the redundant otp rows.
// [R5] bits 8 to 11 each refuse programming of otp sector n.
// [R6] security bit 12 refuses every otp programming operation, security word too.
// [R7] security bit 13 refuses test-port reads and writes of otp.
// [R8] bits 21 to 15 form a software field with no hardware effect.
// [R9] bits 31 to 22 extend the test-port user identification code.
// [R10] one boundary-scan port with 4-bit instruction, 32-bit data register.
// [R11] behind the scan port, a chip port reaches the tile.
// [R12] host holds test reset low at least 100 ns after power up.
// [R13] test logic stays in reset while test reset is low.
// [R14] id instruction returns version, part number and maker fields.
// [R15] permission bit 31 makes config registers read only; bits 30 to 1 reserved.
// [R16] outside agents reach config registers only by config transactions.
// [R17] processor reads and writes status registers with status operations.
// [R18] config copy register returns the security word loaded from otp.
// [R19] set lock bits stay set until reset.
module tsg_guard (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // otp security word load
  input  wire logic        otpSecValid,
  input  wire logic [31:0] otpSecWord,
  // processor status operations
  input  wire logic        psReq,
  input  wire logic        psWrite,
  input  wire logic [7:0]  psAddr,
  input  wire logic [31:0] psWdata,
  output logic             psAck,
  output logic [31:0]      psRdata,
  // configuration transactions
  input  wire logic        cfgReq,
  input  wire logic        cfgWrite,
  input  wire logic        cfgFromSwitch,
  input  wire logic [7:0]  cfgAddr,
  input  wire logic [31:0] cfgWdata,
  output logic             cfgAck,
  output logic             cfgErr,
  output logic [31:0]      cfgRdata,
  // otp programming request
  input  wire logic        otpProgReq,
  input  wire logic [1:0]  otpProgSector,
  input  wire logic        otpProgSecWord,
  output logic             otpProgGrant,
  output logic             otpProgDeny,
  // boot and otp control
  output logic [31:0]      bootAddr,
  output logic             bootFromOtp,
  output logic             otpRedundantEn,
  // test port pins
  input  wire logic        tck,
  input  wire logic        trstN,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdoEn,
  // test port traffic toward tile
  output logic             testWordValid,
  output logic             testWordOtp,
  output logic [31:0]      testWord
);
  logic [31:0] sec_r, perm_r;
  logic [2:0]  secTck_r;
  logic [9:0]  userTck_r;
  logic [2:0]  secTckS;
  logic [9:0]  userTckS;
  logic        tapToggle, toggleS, toggleSeen_r;
  logic [31:0] tapWord;
  logic [3:0]  tapIr;
  logic        cfgWrAllowed;

  // ==========================================================
  // security word from otp
  always_ff @(posedge sys_clk) begin
    if (sys_rst) sec_r <= tsg_pkg::SEC_RESET_VAL;
    else if (otpSecValid) sec_r <= sec_r | otpSecWord; // R19
    else if (psReq && psWrite && psAddr == tsg_pkg::SECURITY_CONFIGURATION_OFS) begin
      // set bits cannot be cleared
      sec_r <= sec_r | psWdata; // R17 R19 R8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bootFromOtp    <= 1'b0;
      bootAddr       <= tsg_pkg::BOOT_ROM_ADDR;
      otpRedundantEn <= 1'b0;
    end else begin
      bootFromOtp    <= sec_r[tsg_pkg::SEC_SECURE_BOOT_BIT]; // R3
      bootAddr       <= sec_r[tsg_pkg::SEC_SECURE_BOOT_BIT] ?
                        tsg_pkg::OTP_BOOT_ADDR : tsg_pkg::BOOT_ROM_ADDR; // R3
      otpRedundantEn <= sec_r[tsg_pkg::SEC_REDUNDANT_BIT]; // R4
    end
  end

  // ==========================================================
  // otp programming locks
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      otpProgGrant <= 1'b0;
      otpProgDeny  <= 1'b0;
    end else begin
      otpProgGrant <= 1'b0;
      otpProgDeny  <= 1'b0;
      if (otpProgReq) begin
        if (sec_r[tsg_pkg::SEC_MASTER_LOCK_BIT] ||
            (!otpProgSecWord && sec_r[tsg_pkg::SEC_SECTOR_LOCK_LSB + 32'(otpProgSector)]))
          otpProgDeny  <= 1'b1; // R5 R6
        else
          otpProgGrant <= 1'b1;
      end
    end
  end

  // ==========================================================
  // processor status operations
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      psAck   <= 1'b0;
      psRdata <= 32'h0000_0000;
    end else begin
      psAck   <= psReq; // R17
      psRdata <= 32'h0000_0000;
      if (psReq && !psWrite && psAddr == tsg_pkg::SECURITY_CONFIGURATION_OFS)
        psRdata <= sec_r; // R17
    end
  end

  // ==========================================================
  // configuration transactions
  assign cfgWrAllowed = !perm_r[tsg_pkg::PERM_RO_BIT]; // R15

  always_ff @(posedge sys_clk) begin
    if (sys_rst) perm_r <= tsg_pkg::PERM_RESET_VAL;
    else if (cfgReq && cfgWrite && cfgAddr == tsg_pkg::DEBUG_PERMISSION_CONTROL_OFS &&
             !(cfgFromSwitch && sec_r[tsg_pkg::SEC_NO_LINK_BIT]) && cfgWrAllowed)
      perm_r <= {cfgWdata[tsg_pkg::PERM_RO_BIT], 31'h0000_0000}; // R15 R16
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfgAck   <= 1'b0;
      cfgErr   <= 1'b0;
      cfgRdata <= 32'h0000_0000;
    end else begin
      cfgAck   <= cfgReq; // R16
      cfgErr   <= 1'b0;
      cfgRdata <= 32'h0000_0000;
      if (cfgReq) begin
        if (cfgFromSwitch && sec_r[tsg_pkg::SEC_NO_LINK_BIT]) begin
          cfgErr <= 1'b1; // R2
        end else if (cfgWrite) begin
          cfgErr <= !cfgWrAllowed ||
                    cfgAddr != tsg_pkg::DEBUG_PERMISSION_CONTROL_OFS; // R15
        end else begin
          case (cfgAddr)
            tsg_pkg::DEBUG_PERMISSION_CONTROL_OFS:   cfgRdata <= perm_r;
            tsg_pkg::SECURITY_CONFIGURATION_COPY_OFS: cfgRdata <= sec_r; // R18
            default:                                 cfgErr   <= 1'b1;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // levels toward test domain
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      secTck_r  <= 3'h0;
      userTck_r <= 10'h000;
    end else begin
      secTck_r  <= {perm_r[tsg_pkg::PERM_RO_BIT],
                    sec_r[tsg_pkg::SEC_NO_TEST_OTP_BIT],
                    sec_r[tsg_pkg::SEC_NO_TEST_PORT_BIT]};
      userTck_r <= sec_r[tsg_pkg::SEC_USERID_MSB:tsg_pkg::SEC_USERID_LSB]; // R9
    end
  end

  tsg_sync #(.W(13)) u_sync_tck (
    .clk  (tck),
    .rst  (!trstN),
    .din  ({secTck_r, userTck_r}),
    .dout ({secTckS, userTckS})
  );

  tsg_tap u_tap (
    .tck       (tck),
    .trstN     (trstN),
    .tms       (tms),
    .tdi       (tdi),
    .tdo       (tdo),
    .tdoEn     (tdoEn),
    .blockTile (secTckS[0] | secTckS[2]),
    .blockOtp  (secTckS[0] | secTckS[1]),
    .userIdExt (userTckS),
    .updWord   (tapWord),
    .updIr     (tapIr),
    .updToggle (tapToggle)
  ); // R10 R13

  // ==========================================================
  // test word crossing back to sys_clk
  // not reset: a toggle seen before reset is not replayed
  tsg_sync #(.W(1)) u_sync_sys (
    .clk  (sys_clk),
    .rst  (1'b0),
    .din  (tapToggle),
    .dout (toggleS)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      toggleSeen_r  <= toggleS;
      testWordValid <= 1'b0;
      testWordOtp   <= 1'b0;
      testWord      <= 32'h0000_0000;
    end else begin
      toggleSeen_r  <= toggleS;
      testWordValid <= 1'b0;
      // recheck locks in this domain too
      if (toggleS != toggleSeen_r) begin
        if (tapIr == tsg_pkg::IR_OTP_ACCESS) begin
          if (!sec_r[tsg_pkg::SEC_NO_TEST_PORT_BIT] &&
              !sec_r[tsg_pkg::SEC_NO_TEST_OTP_BIT]) begin // R7 R1
            testWordValid <= 1'b1;
            testWordOtp   <= 1'b1;
            testWord      <= tapWord;
          end
        end else if (!sec_r[tsg_pkg::SEC_NO_TEST_PORT_BIT]) begin // R1 R11
          testWordValid <= 1'b1;
          testWordOtp   <= 1'b0;
          testWord      <= tapWord;
        end
      end
    end
  end
endmodule

/* testbench/tsg_guard_chk.sv */
/*
  concurrent checks on the guard's sys_clk ports, bound into the guard.
  assumes locks arrive only through the otp load strobe.
*/
module tsg_guard_chk (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        sys_rst,
  // security word load
  input wire logic        otpSecValid,
  input wire logic [31:0] otpSecWord,
  // requests
  input wire logic        psReq,
  input wire logic        cfgReq,
  input wire logic        cfgWrite,
  input wire logic        cfgFromSwitch,
  input wire logic [7:0]  cfgAddr,
  input wire logic [31:0] cfgWdata,
  input wire logic        otpProgReq,
  input wire logic [1:0]  otpProgSector,
  input wire logic        otpProgSecWord,
  // answers
  input wire logic        psAck,
  input wire logic        cfgAck,
  input wire logic        cfgErr,
  input wire logic        otpProgGrant,
  input wire logic        otpProgDeny,
  input wire logic        bootFromOtp,
  input wire logic        otpRedundantEn,
  input wire logic        testWordValid,
  input wire logic        testWordOtp
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] secR;
  logic        permR;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // shadow of the lock word and the read-only permission
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      secR <= '0;
    end else if (otpSecValid) begin
      secR <= secR | otpSecWord;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      permR <= 1'b0;
    end else if (cfgReq && cfgWrite && cfgAddr == 8'h04 && cfgWdata[31]
                 && !(cfgFromSwitch && secR[1])) begin
      permR <= 1'b1;
    end
  end
  // ==========================================================
  // assertions
  a_status_ack: assert property (psReq |=> psAck)
    else $error("status op not answered");
  a_cfg_ack: assert property (cfgReq |=> cfgAck)
    else $error("config op not answered");
  a_err_paired: assert property (cfgErr |-> cfgAck)
    else $error("config error without ack");
  a_switch_refused: assert property (cfgReq && cfgFromSwitch && secR[1] |=> cfgErr)
    else $error("switch access not refused");
  a_perm_ro: assert property (cfgReq && cfgWrite && permR |=> cfgErr)
    else $error("write allowed while read only");
  a_master_lock: assert property (otpProgReq && secR[12] |=> otpProgDeny && !otpProgGrant)
    else $error("programming allowed under master lock");
  a_sector_lock: assert property (otpProgReq && !otpProgSecWord
    && secR[8 + otpProgSector] |=> otpProgDeny) else $error("locked sector programmed");
  a_prog_answer: assert property (otpProgReq |=> otpProgGrant ^ otpProgDeny)
    else $error("programming answer missing");
  a_boot_follow: assert property (bootFromOtp == $past(secR[5])
    && otpRedundantEn == $past(secR[7])) else $error("boot or redundancy level wrong");
  a_lock_sticky: assert property (!$fell(bootFromOtp) && !$fell(otpRedundantEn))
    else $error("lock level cleared");
  a_test_block: assert property (testWordValid |-> !$past(secR[0])
    && !(testWordOtp && $past(secR[13]))) else $error("blocked test word delivered");
endmodule

bind tsg_guard tsg_guard_chk chk (
  .sys_clk, .sys_rst, .otpSecValid, .otpSecWord, .psReq, .cfgReq, .cfgWrite,
  .cfgFromSwitch, .cfgAddr, .cfgWdata, .otpProgReq, .otpProgSector, .otpProgSecWord,
  .psAck, .cfgAck, .cfgErr, .otpProgGrant, .otpProgDeny, .bootFromOtp,
  .otpRedundantEn, .testWordValid, .testWordOtp
);

/* testbench/tsg_jtag_host.sv */
/*
  behavioural test-port host: 80 ns test clock, only within frames.
  assumes tdo changes on the falling test clock edge.
*/
module tsg_jtag_host (
  // test pins
  output logic      tck,
  output logic      trstN,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {tck, trstN, tms, tdi} = 4'b0010;
  end
  // one clock, sampled at the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    {tms, tdi} = {m, d};
    #40 tck = 1'b1;
    o = tdo;
    #40 tck = 1'b0;
  endtask
  task automatic rst_tap();
    logic o;
    #1.3 trstN = 1'b0;
    #200 trstN = 1'b1;
    repeat (5) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
  // idle to shift, n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] d,
                      output logic [31:0] q);
    logic o;
    q = '0;
    #1.3 step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], o);
      q[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, ~d[n-1], o);
  endtask
endmodule

/* testbench/test_tile_security_debug_access_guard.sv */
/*
  self-checking bench for the security and debug-access guard.
  assumes the host model drives the test pins and the checker is bound.
*/
module test_tile_security_debug_access_guard;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] ID = {tsg_pkg::ID_VERSION, tsg_pkg::ID_PART, tsg_pkg::ID_MAKER, 1'b1};
  logic        sys_clk = 1'b0, sys_rst = 1'b1;
  logic        otpSecValid, psReq, psWrite, cfgReq, cfgWrite, cfgFromSwitch, otpProgReq;
  logic        otpProgSecWord, psAck, cfgAck, cfgErr, otpProgGrant, otpProgDeny;
  logic        bootFromOtp, otpRedundantEn, testWordValid, testWordOtp;
  logic        tck, trstN, tms, tdi, tdo, tdoEn;
  logic [1:0]  otpProgSector;
  logic [7:0]  psAddr, cfgAddr;
  logic [31:0] otpSecWord, psWdata, psRdata, cfgWdata, cfgRdata, bootAddr, testWord;
  logic [31:0] sec, d, q, uid;
  logic [33:0] psQ[$], cfgQ[$], prQ[$], twQ[$];
  int          fails = 0, checks = 0;
  always #2.5 sys_clk = ~sys_clk;
  tsg_guard dut (
    .sys_clk, .sys_rst, .otpSecValid, .otpSecWord, .psReq, .psWrite, .psAddr, .psWdata,
    .psAck, .psRdata, .cfgReq, .cfgWrite, .cfgFromSwitch, .cfgAddr, .cfgWdata, .cfgAck,
    .cfgErr, .cfgRdata, .otpProgReq, .otpProgSector, .otpProgSecWord, .otpProgGrant,
    .otpProgDeny, .bootAddr, .bootFromOtp, .otpRedundantEn, .tck, .trstN, .tms, .tdi,
    .tdo, .tdoEn, .testWordValid, .testWordOtp, .testWord
  );
  tsg_jtag_host host (.tck, .trstN, .tms, .tdi, .tdo);
  // ==========================================================
  // compare and report
  task automatic chk(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // top bit of a note says whether the read data counts
  task automatic pick(input string n, ref logic [33:0] qu[$], input logic [32:0] g);
    logic [33:0] e;
    e = qu.size() > 0 ? qu.pop_front() : 'x;
    chk(n, e, {e[33], e[33] ? g : {g[32], e[31:0]}});
  endtask
  task automatic stop_test();
    fails += psQ.size() + cfgQ.size() + prQ.size() + twQ.size();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(negedge sys_clk) begin
    if (!sys_rst) begin
      if (psAck) pick("psRdata", psQ, {1'b0, psRdata});
      if (cfgAck) pick("cfgResult", cfgQ, {cfgErr, cfgRdata});
      if (otpProgGrant || otpProgDeny) pick("progAnswer", prQ, {31'd0, otpProgGrant, otpProgDeny});
      if (testWordValid) pick("testWord", twQ, {testWordOtp, testWord});
    end
  end
  initial begin
    #400_000;
    fails++;
    stop_test();
  end
  // ==========================================================
  // drivers
  task automatic ps(input logic w, input logic [7:0] a, input logic [31:0] dd, e);
    psQ.push_back({~w, 1'b0, e});
    @(negedge sys_clk) {psReq, psWrite, psAddr, psWdata} = {1'b1, w, a, dd};
    @(negedge sys_clk) psReq = 1'b0;
  endtask
  task automatic cfg(input logic w, s, input logic [7:0] a, input logic [31:0] dd,
                     input logic er, input logic [31:0] e);
    cfgQ.push_back({~w & ~er, er, e});
    @(negedge sys_clk) {cfgReq, cfgWrite, cfgFromSwitch, cfgAddr, cfgWdata} = {1'b1, w, s, a, dd};
    @(negedge sys_clk) cfgReq = 1'b0;
  endtask
  task automatic prog(input logic s, input logic [1:0] n, input logic dn);
    prQ.push_back({1'b1, 31'd0, ~dn, dn});
    @(negedge sys_clk) {otpProgReq, otpProgSecWord, otpProgSector} = {1'b1, s, n};
    @(negedge sys_clk) otpProgReq = 1'b0;
  endtask
  task automatic load(input logic [31:0] w);
    sec |= w;
    @(negedge sys_clk) {otpSecValid, otpSecWord} = {1'b1, w};
    @(negedge sys_clk) otpSecValid = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic jt(input logic [3:0] ir, input logic [31:0] di, output logic [31:0] qo);
    logic [31:0] c;
    host.scan(1'b1, 4, {28'd0, ir}, c);
    chk("irCapture", 34'h1, {30'd0, c[3:0]});
    host.scan(1'b0, 32, di, qo);
    chk("tdoEn", 34'h0, {33'd0, tdoEn});
    repeat (20) @(negedge sys_clk);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    {otpSecValid, psReq, psWrite, cfgReq, cfgWrite, cfgFromSwitch, otpProgReq} = '0;
    {otpProgSecWord, otpProgSector, psAddr, cfgAddr, otpSecWord, psWdata, cfgWdata} = '0;
    sec = '0;
    void'($urandom(74));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) sys_rst = 1'b0;
    ps(1'b0, 8'h05, '0, '0);
    cfg(1'b0, 1'b0, 8'h07, '0, 1'b0, '0);
    cfg(1'b0, 1'b0, 8'h04, '0, 1'b0, '0);
    host.rst_tap();
    host.scan(1'b0, 32, '0, q);
    chk("idcode", {2'b0, ID}, {2'b0, q});
    for (int n = 0; n < 4; n++) prog(1'b0, n[1:0], 1'b0);
    for (int k = 8; k < 10; k++) begin
      d = $urandom();
      twQ.push_back({1'b1, k == 9, d});
      jt(k[3:0], d, q);
    end
    uid = $urandom();
    load({uid[9:0], 22'h1A2});
    chk("boot", {2'b11, tsg_pkg::OTP_BOOT_ADDR}, {bootFromOtp, otpRedundantEn, bootAddr});
    ps(1'b0, 8'h05, '0, sec);
    cfg(1'b0, 1'b0, 8'h07, '0, 1'b0, sec);
    cfg(1'b0, 1'b1, 8'h04, '0, 1'b1, '0);
    for (int n = 0; n < 4; n++) prog(1'b0, n[1:0], n == 0);
    prog(1'b1, 2'd0, 1'b0);
    jt(tsg_pkg::IR_USERCODE, '0, q);
    chk("usercode", {2'b0, uid[9:0], 22'h0}, {2'b0, q});
    host.rst_tap();
    host.scan(1'b0, 32, '0, q);
    chk("idcode", {2'b0, ID}, {2'b0, q});
    d = {10'h0, 7'($urandom()), 15'h0};
    ps(1'b1, 8'h05, d, '0);
    sec |= d;
    ps(1'b0, 8'h05, '0, sec);
    ps(1'b1, 8'h30, d, '0);
    ps(1'b0, 8'h30, '0, '0);
    load(32'h0000_2000);
    twQ.push_back({2'b10, d});
    jt(tsg_pkg::IR_CHIP_TAP, d, q);
    jt(tsg_pkg::IR_OTP_ACCESS, d, q);
    load(32'h0000_0001);
    jt(tsg_pkg::IR_CHIP_TAP, d, q);
    load(32'h0000_1000);
    prog(1'b1, 2'd3, 1'b1);
    prog(1'b0, 2'd3, 1'b1);
    cfg(1'b1, 1'b0, 8'h04, 32'hFFFF_FFFF, 1'b0, '0);
    cfg(1'b0, 1'b0, 8'h04, '0, 1'b0, 32'h8000_0000);
    cfg(1'b1, 1'b0, 8'h04, '0, 1'b1, '0);
    cfg(1'b1, 1'b0, 8'h06, '0, 1'b1, '0);
    cfg(1'b0, 1'b0, 8'h20, '0, 1'b1, '0);
    @(negedge sys_clk) sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    sec = '0;
    ps(1'b0, 8'h05, '0, '0);
    cfg(1'b0, 1'b0, 8'h04, '0, 1'b0, '0);
    repeat (4) @(negedge sys_clk);
    stop_test();
  end
endmodule
